// File: hw/phba_top.sv
// pci-x host bridge adapter core: arbitration, translation, irq, speed
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
module phba_top
   import phba_pkg::*;
#(
   parameter int NMAP = phba_pkg::PHBA_NMAP,
   parameter int NREQ = phba_pkg::PHBA_NREQ
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // arbitration
   input wire logic [NREQ-1:0] bus_req_i,
   output logic [NREQ-1:0] bus_gnt_o,
   // inbound dma request
   input wire logic dma_valid_i,
   input wire logic dma_dac_i,
   input wire logic [63:0] dma_addr_i,
   input wire logic [63:0] dma_data_i,
   input wire logic dma_lock_i,
   input wire logic dma_sbo_i,
   input wire logic dma_sdone_i,
   output logic dma_pa_valid_o,
   output logic [49:0] dma_pa_o,
   output logic [63:0] dma_data_o,
   output logic dma_err_o,
   // write issue and completion from fabric, per slot
   input wire logic [PHBA_NSLOT-1:0] wr_issue_i,
   input wire logic [PHBA_NSLOT-1:0] wr_done_i,
   // card interrupt lines, active high, per slot
   input wire logic [PHBA_NSLOT-1:0] int_a_i,
   input wire logic [PHBA_NSLOT-1:0] int_b_i,
   input wire logic [PHBA_NSLOT-1:0] int_c_i,
   input wire logic [PHBA_NSLOT-1:0] int_d_i,
   output logic [PHBA_NIRQ-1:0] irq_o,
   // outbound pio request
   input wire logic pio_valid_i,
   input wire logic [63:0] pio_addr_i,
   output logic pio_fwd_o,
   output logic [31:0] pio_addr_o,
   // speed capability of the two bus slots
   input wire logic [1:0] card_present_i,
   input wire logic [1:0] card_pcix_i,
   input wire logic [3:0] card_cap_i,
   output logic [1:0] bus_speed_o
);
   localparam int MDW = PHBA_PA_W - PHBA_PAGE_W;

   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [NREQ-1:0] group_ff, nxt_group;
   logic [31:0] piobase_ff, nxt_piobase, piolim_ff, nxt_piolim;
   logic [NMAP-1:0] mapused_ff, nxt_mapused;
   logic [31:0] mapres_ff, nxt_mapres;
   logic [MDW-1:0] mapaddr_ff, nxt_mapaddr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [NREQ-1:0] gnt_ff, nxt_gnt;
   logic [1:0] speed_ff, nxt_speed;
   logic [PHBA_NIRQ-1:0] irq_ff, nxt_irq;
   logic [PHBA_NSLOT-1:0] pend_ff, nxt_pend;
   logic pio_fwd_ff, nxt_pio_fwd;
   logic [31:0] pio_addr_ff, nxt_pio_addr;
   logic dval_ff, nxt_dval, d32_ff, nxt_d32, derr_ff, nxt_derr;
   logic [63:0] daddr_ff, nxt_daddr, ddata_ff, nxt_ddata;
   logic dval2_ff, nxt_dval2, derr2_ff, nxt_derr2;
   logic [49:0] pa_ff, nxt_pa;
   logic [63:0] data2_ff, nxt_data2;
   logic [NREQ-1:0] rt_pick, lo_pick;
   logic rt_any, lo_any, gnt_take;
   logic map_wr;
   logic [PHBA_MAPIDX_W-1:0] map_free_idx;
   logic map_free_ok;
   logic [MDW-1:0] map_rdata;
   logic [PHBA_NSLOT-1:0] ac_line, bd_line, slot_int;
   logic [3:0] wcnt_ff [PHBA_NSLOT];
   logic [3:0] nxt_wcnt [PHBA_NSLOT];

   // ---- arbitration, two groups
   phba_rr #(.N(NREQ)) u_rr_rt (
      .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .req_i(bus_req_i & group_ff), .take_i(gnt_take),
      .pick_o(rt_pick), .any_o(rt_any));
   phba_rr #(.N(NREQ)) u_rr_lo (
      .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .req_i(bus_req_i & ~group_ff), .take_i(gnt_take && !rt_any),
      .pick_o(lo_pick), .any_o(lo_any));

   always_comb
   begin
      // a new grant is chosen only when the holder has dropped its request
      gnt_take = ctrl_ff[PHBA_CTRL_EN_BIT] && ((gnt_ff & bus_req_i) == '0);
      nxt_gnt = gnt_ff & bus_req_i;
      if (gnt_take)
         nxt_gnt = rt_any ? rt_pick : (lo_any ? lo_pick : '0);
   end

   // ---- speed: slowest card wins, 133 only with a lone card
   always_comb
   begin
      logic [1:0] c0, c1;
      c0 = card_cap_i[1:0];
      c1 = card_cap_i[3:2];
      if (!card_pcix_i[0] && c0 > PHBA_SPD_66)
         c0 = PHBA_SPD_66;
      if (!card_pcix_i[1] && c1 > PHBA_SPD_66)
         c1 = PHBA_SPD_66;
      unique case (card_present_i)
         2'b01: nxt_speed = c0;
         2'b10: nxt_speed = c1;
         2'b11:
         begin
            nxt_speed = (c0 < c1) ? c0 : c1;
            if (nxt_speed == PHBA_SPD_133)
               nxt_speed = PHBA_SPD_100;
         end
         2'b00: nxt_speed = PHBA_SPD_33;
      endcase
      // other slot not configured down: a lone card may not take 133
      if (ctrl_ff[PHBA_CTRL_SLOT2_BIT] && nxt_speed == PHBA_SPD_133)
         nxt_speed = PHBA_SPD_100;
   end

   // ---- interrupts: a/c and b/d merged, held until writes drain
   always_comb
   begin
      ac_line = int_a_i | int_c_i;
      bd_line = int_b_i | int_d_i;
      for (int n = 0; n < PHBA_NSLOT; n++)
      begin
         nxt_wcnt[n] = wcnt_ff[n];
         if (wr_issue_i[n] && !wr_done_i[n])
            nxt_wcnt[n] = wcnt_ff[n] + 4'h1;
         else if (!wr_issue_i[n] && wr_done_i[n] && wcnt_ff[n] != 4'h0)
            nxt_wcnt[n] = wcnt_ff[n] - 4'h1;
         slot_int[n] = ac_line[n] | bd_line[n];
         // released only once every earlier write has completed
         nxt_pend[n] = slot_int[n] && (wcnt_ff[n] != 4'h0 ||
                       wr_issue_i[n]);
      end
      nxt_irq = '0;
      for (int n = 0; n < PHBA_NSLOT; n++)
      begin
         if (!nxt_pend[n] && !pend_ff[n])
         begin
            nxt_irq[n] = nxt_irq[n] | ac_line[n];
            nxt_irq[(n + 4) % 8] = nxt_irq[(n + 4) % 8] | bd_line[n];
         end
      end
   end

   // ---- pio forwarding, 32-bit only, low window
   always_comb
   begin
      nxt_pio_fwd = 1'b0;
      nxt_pio_addr = pio_fwd_ff ? pio_addr_ff : 32'h0000_0000;
      if (pio_valid_i && pio_addr_i[63:32] == 32'h0000_0000 &&
          pio_addr_i[31:0] >= piobase_ff && pio_addr_i[31:0] < piolim_ff)
      begin
         nxt_pio_fwd = 1'b1;
         nxt_pio_addr = pio_addr_i[31:0];
      end
   end

   // ---- dma translation: stage 1 captures, stage 2 forms address
   // lock and snoop inputs are deliberately left unread
   always_comb
   begin
      nxt_dval = dma_valid_i && ctrl_ff[PHBA_CTRL_EN_BIT];
      nxt_d32 = !dma_dac_i;
      nxt_daddr = dma_addr_i;
      nxt_ddata = dma_data_i;
      nxt_derr = 1'b0;
      if (!dma_dac_i && !mapused_ff[dma_addr_i[PHBA_PAGE_W +:
           PHBA_MAPIDX_W]])
         nxt_derr = dma_valid_i;
      nxt_dval2 = dval_ff && !derr_ff;
      nxt_derr2 = dval_ff && derr_ff;
      nxt_data2 = ddata_ff;
      if (d32_ff)
         nxt_pa = {map_rdata, daddr_ff[PHBA_PAGE_W-1:0]};
      else
         nxt_pa = daddr_ff[49:0];
      // no ordering is enforced across separate transactions
      if (!dval_ff)
         nxt_pa = pa_ff;
   end

   phba_maptab #(.DEPTH(NMAP), .AW(PHBA_MAPIDX_W), .DW(MDW)) u_map (
      .clock_i(clock_i), .ce_i(ce_i), .wr_i(map_wr),
      .waddr_i(map_free_idx), .wdata_i(mapaddr_ff),
      .raddr_i(dma_addr_i[PHBA_PAGE_W +: PHBA_MAPIDX_W]),
      .rdata_o(map_rdata));

   // ---- register port
   always_comb
   begin
      map_free_ok = 1'b0;
      map_free_idx = '0;
      for (int i = NMAP - 1; i >= 0; i--)
         if (!mapused_ff[i])
         begin
            map_free_ok = 1'b1;
            map_free_idx = PHBA_MAPIDX_W'(i);
         end
      nxt_ctrl = ctrl_ff;
      nxt_group = group_ff;
      nxt_piobase = piobase_ff;
      nxt_piolim = piolim_ff;
      nxt_mapused = mapused_ff;
      nxt_mapres = mapres_ff;
      nxt_mapaddr = mapaddr_ff;
      map_wr = 1'b0;
      nxt_rdata = 32'h0000_0000;
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            PHBA_REG_CTRL: nxt_ctrl = reg_wdata_i & 32'h0000_0003;
            PHBA_REG_GROUP: nxt_group = reg_wdata_i[NREQ-1:0];
            PHBA_REG_PIOBASE: nxt_piobase = reg_wdata_i;
            PHBA_REG_PIOLIM: nxt_piolim = reg_wdata_i;
            PHBA_REG_MAPADDR: nxt_mapaddr = MDW'(reg_wdata_i);
            PHBA_REG_MAPREQ:
            begin
               nxt_mapres = 32'h0000_0000;
               if (map_free_ok)
               begin
                  map_wr = 1'b1;
                  nxt_mapused[map_free_idx] = 1'b1;
                  nxt_mapres[PHBA_MAPRES_OK_BIT] = 1'b1;
                  nxt_mapres[PHBA_MAPIDX_W-1:0] = map_free_idx;
               end
               else
                  nxt_mapres[PHBA_MAPRES_FAIL_BIT] = 1'b1;
            end
            PHBA_REG_MAPFREE:
               nxt_mapused[reg_wdata_i[PHBA_MAPIDX_W-1:0]] = 1'b0;
            default: ;
         endcase
      end
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            PHBA_REG_CTRL: nxt_rdata = ctrl_ff;
            PHBA_REG_STAT: nxt_rdata = 32'(mapused_ff);
            PHBA_REG_GROUP: nxt_rdata = 32'(group_ff);
            PHBA_REG_SPEED: nxt_rdata = {30'h0000_0000, speed_ff};
            PHBA_REG_MAPRES: nxt_rdata = mapres_ff;
            PHBA_REG_IRQ: nxt_rdata = {16'h0000, pend_ff, irq_ff};
            PHBA_REG_PIOBASE: nxt_rdata = piobase_ff;
            PHBA_REG_PIOLIM: nxt_rdata = piolim_ff;
            PHBA_REG_MAPADDR: nxt_rdata = mapaddr_ff[31:0];
            default: nxt_rdata = PHBA_BAD_RD;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_ff <= PHBA_CTRL_RST;
         group_ff <= PHBA_GROUP_RST[NREQ-1:0];
         piobase_ff <= 32'h0000_0000;
         piolim_ff <= PHBA_PIOLIM_RST;
         mapused_ff <= '0;
         mapres_ff <= 32'h0000_0000;
         mapaddr_ff <= '0;
         rdata_ff <= 32'h0000_0000;
         gnt_ff <= '0;
         speed_ff <= PHBA_SPD_33;
         irq_ff <= '0;
         pend_ff <= '0;
         pio_fwd_ff <= 1'b0;
         pio_addr_ff <= 32'h0000_0000;
         dval_ff <= 1'b0;
         d32_ff <= 1'b0;
         derr_ff <= 1'b0;
         daddr_ff <= '0;
         ddata_ff <= '0;
         dval2_ff <= 1'b0;
         derr2_ff <= 1'b0;
         pa_ff <= '0;
         data2_ff <= '0;
         for (int n = 0; n < PHBA_NSLOT; n++)
            wcnt_ff[n] <= 4'h0;
      end
      else if (ce_i)
      begin
         ctrl_ff <= nxt_ctrl;
         group_ff <= nxt_group;
         piobase_ff <= nxt_piobase;
         piolim_ff <= nxt_piolim;
         mapused_ff <= nxt_mapused;
         mapres_ff <= nxt_mapres;
         mapaddr_ff <= nxt_mapaddr;
         rdata_ff <= nxt_rdata;
         gnt_ff <= nxt_gnt;
         speed_ff <= nxt_speed;
         irq_ff <= nxt_irq;
         pend_ff <= nxt_pend;
         pio_fwd_ff <= nxt_pio_fwd;
         pio_addr_ff <= nxt_pio_addr;
         dval_ff <= nxt_dval;
         d32_ff <= nxt_d32;
         derr_ff <= nxt_derr;
         daddr_ff <= nxt_daddr;
         ddata_ff <= nxt_ddata;
         dval2_ff <= nxt_dval2;
         derr2_ff <= nxt_derr2;
         pa_ff <= nxt_pa;
         data2_ff <= nxt_data2;
         for (int n = 0; n < PHBA_NSLOT; n++)
            wcnt_ff[n] <= nxt_wcnt[n];
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign bus_gnt_o = gnt_ff;
   assign bus_speed_o = speed_ff;
   assign irq_o = irq_ff;
   assign pio_fwd_o = pio_fwd_ff;
   assign pio_addr_o = pio_addr_ff;
   assign dma_pa_valid_o = dval2_ff;
   assign dma_pa_o = pa_ff;
   assign dma_data_o = data2_ff;
   assign dma_err_o = derr2_ff;
endmodule

// File: hw/phba_pkg.sv
// package: constants and types of the pci-x host bridge adapter
// How it works
// - separate transactions are not ordered; status may overtake earlier dma data.
// - a card's interrupt is held until all its earlier writes complete.
// - lock signal is ignored; no locked access is offered to masters.
// - snoop signals are ignored; coherency is kept by bridge and memory.
// - as target the bridge accepts 64-bit master addresses and 64-bit data.
// - as initiator only pio is issued, always with 32-bit addresses.
// - 133 mhz needs one card alone; two cards run 100/66 or 66/33.
// - with mixed cards the bus runs at the slowest card's speed.
// - pio memory windows sit in the lowest bus region and are forwarded.
// - inbound dma addresses translate to a 50-bit physical address.
// - 32-bit masters use a limited pool of map registers; allocation may fail.
// - 64-bit dma addresses translate directly without using map registers.
// - arbiter has real-time and low groups, each round-robin.
// - any real-time request is granted ahead of the low group.
// - lines a and c share one signal, b and d share another.
// - slot n a/c feeds input n, b/d feeds input (n+4) mod 8.
package phba_pkg;
   localparam int PHBA_NSLOT = 8;
   localparam int PHBA_NIRQ = 8;
   localparam int PHBA_NREQ = 4;
   localparam int PHBA_NMAP = 8;
   localparam int PHBA_PA_W = 50;
   localparam int PHBA_PAGE_W = 12;
   localparam int PHBA_MAPIDX_W = 3;
   // register offsets
   localparam logic [7:0] PHBA_REG_CTRL = 8'h00;
   localparam logic [7:0] PHBA_REG_STAT = 8'h04;
   localparam logic [7:0] PHBA_REG_GROUP = 8'h08;
   localparam logic [7:0] PHBA_REG_SPEED = 8'h0C;
   localparam logic [7:0] PHBA_REG_MAPREQ = 8'h10;
   localparam logic [7:0] PHBA_REG_MAPRES = 8'h14;
   localparam logic [7:0] PHBA_REG_MAPFREE = 8'h18;
   localparam logic [7:0] PHBA_REG_IRQ = 8'h1C;
   localparam logic [7:0] PHBA_REG_PIOBASE = 8'h20;
   localparam logic [7:0] PHBA_REG_PIOLIM = 8'h24;
   localparam logic [7:0] PHBA_REG_MAPADDR = 8'h28;
   // fields
   localparam int PHBA_CTRL_EN_BIT = 0;
   localparam int PHBA_CTRL_SLOT2_BIT = 1;
   localparam int PHBA_MAPRES_OK_BIT = 31;
   localparam int PHBA_MAPRES_FAIL_BIT = 30;
   // reset values, and the value read back from offsets with no readable register
   localparam logic [31:0] PHBA_CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] PHBA_PIOLIM_RST = 32'h0400_0000;
   localparam logic [31:0] PHBA_GROUP_RST = 32'h0000_0000;
   localparam logic [31:0] PHBA_BAD_RD = 32'hDEAD_0000;
   // bus speed codes (mhz class)
   typedef enum logic [1:0] {
      PHBA_SPD_33, PHBA_SPD_66, PHBA_SPD_100, PHBA_SPD_133
   } phba_speed_t;
endpackage

// File: hw/phba_maptab.sv
// map register pool: address-to-page table, registered read
`timescale 1ns/100ps
module phba_maptab #(
   parameter int DEPTH = 8,
   parameter int AW = 3,
   parameter int DW = 38
) (
   // clock and clock enable, no reset
   input wire logic clock_i,
   input wire logic ce_i,
   // write port
   input wire logic wr_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // read port
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_ff [DEPTH];
   logic [DW-1:0] rdata_ff;

   always_ff @(posedge clock_i)
   begin
      if (ce_i)
      begin
         if (wr_i)
            mem_ff[waddr_i] <= wdata_i;
         rdata_ff <= mem_ff[raddr_i];
      end
   end
   assign rdata_o = rdata_ff;
endmodule

// File: hw/phba_rr.sv
// round-robin grant within one requester group
`timescale 1ns/100ps
module phba_rr #(
   parameter int N = 4
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // requests
   input wire logic [N-1:0] req_i,
   input wire logic take_i,
   // grant choice
   output logic [N-1:0] pick_o,
   output logic any_o
);
   logic [N-1:0] last_ff;
   logic [N-1:0] nxt_last;
   logic [2*N-1:0] dbl;
   logic [2*N-1:0] mask;
   logic [2*N-1:0] win;

   always_comb
   begin
      dbl = {req_i, req_i};
      // ones strictly above the last winner, in the doubled vector
      mask = ~(({last_ff, last_ff} << 1) - {{N{1'b0}}, last_ff}) &
             ~{{N{1'b0}}, (last_ff - {{(N-1){1'b0}}, 1'b1}) | last_ff};
      mask = {~{N{1'b0}}, mask[N-1:0]} &
             {{N{1'b1}}, ~((last_ff << 1) - {{(N-1){1'b0}}, 1'b1})};
      win = dbl & mask;
      win = win & (~win + {{(2*N-1){1'b0}}, 1'b1});
      pick_o = win[N-1:0] | win[2*N-1:N];
      any_o = |req_i;
      nxt_last = last_ff;
      if (take_i && any_o)
         nxt_last = pick_o;
   end

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         last_ff <= {1'b1, {(N-1){1'b0}}};
      else if (ce_i)
         last_ff <= nxt_last;
   end
endmodule

// File: tb/phba_top_assertions.sv
// checker: port-level properties of the bridge adapter core
`timescale 1ns/100ps
module phba_top_chk
   import phba_pkg::*;
#(
   parameter int NMAP = 8,
   parameter int NREQ = 4
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // arbitration
   input wire logic [NREQ-1:0] bus_req_i,
   input wire logic [NREQ-1:0] bus_gnt_o,
   // dma and pio
   input wire logic dma_valid_i,
   input wire logic dma_dac_i,
   input wire logic [63:0] dma_addr_i,
   input wire logic dma_pa_valid_o,
   input wire logic [49:0] dma_pa_o,
   input wire logic dma_err_o,
   input wire logic pio_valid_i,
   input wire logic [63:0] pio_addr_i,
   input wire logic pio_fwd_o,
   input wire logic [31:0] pio_addr_o,
   // interrupts and speed
   input wire logic [phba_pkg::PHBA_NSLOT-1:0] int_a_i,
   input wire logic [phba_pkg::PHBA_NSLOT-1:0] int_b_i,
   input wire logic [phba_pkg::PHBA_NSLOT-1:0] int_c_i,
   input wire logic [phba_pkg::PHBA_NSLOT-1:0] int_d_i,
   input wire logic [phba_pkg::PHBA_NIRQ-1:0] irq_o,
   input wire logic [1:0] card_present_i,
   input wire logic [3:0] card_cap_i,
   input wire logic [1:0] bus_speed_o
);
   logic [7:0] src;
   logic [1:0] slow;
   // irq may only be a masked copy of its sources, never an extra line
   always_comb
   begin
      for (int k = 0; k < 8; k++)
         src[k] = int_a_i[k] | int_c_i[k] | int_b_i[(k+4)%8]
            | int_d_i[(k+4)%8];
      slow = card_cap_i[1:0];
      if (card_cap_i[3:2] < card_cap_i[1:0])
         slow = card_cap_i[3:2];
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   a_gnt_onehot: assert property ($onehot0(bus_gnt_o))
      else $error("grant not one-hot");
   a_gnt_to_req: assert property (|(bus_gnt_o & ~$past(bus_gnt_o))
      |-> |(bus_gnt_o & ~$past(bus_gnt_o) & $past(bus_req_i)))
      else $error("grant to idle requester");
   a_gnt_hold: assert property (ce_i && |(bus_gnt_o & bus_req_i)
      |=> $stable(bus_gnt_o)) else $error("grant taken from holder");
   a_dma_wide: assert property (dma_valid_i && dma_dac_i && ce_i
      |-> ##2 dma_pa_valid_o && dma_pa_o == 50'($past(dma_addr_i, 2)))
      else $error("wide dma address not passed through");
   a_dma_excl: assert property (!(dma_pa_valid_o && dma_err_o))
      else $error("dma valid and error together");
   a_pio_narrow: assert property (pio_valid_i && ce_i
      && pio_addr_i[63:32] != 32'h0000_0000 |=> !pio_fwd_o)
      else $error("pio above 32 bits forwarded");
   a_pio_source: assert property (pio_fwd_o |-> $past(pio_valid_i)
      && pio_addr_o == 32'($past(pio_addr_i)))
      else $error("pio forward without request");
   a_irq_route: assert property ((irq_o & ~$past(src)) == 8'h00)
      else $error("irq raised without mapped source");
   a_spd_two: assert property (ce_i && card_present_i == 2'b11
      |=> bus_speed_o != PHBA_SPD_133) else $error("two cards at top speed");
   a_spd_slow: assert property (ce_i && card_present_i == 2'b11
      |=> bus_speed_o <= $past(slow)) else $error("faster than slowest card");
endmodule

bind phba_top phba_top_chk #(.NMAP(NMAP), .NREQ(NREQ)) i_phba_top_chk (
   .clock_i, .resetn_i, .ce_i, .bus_req_i, .bus_gnt_o, .dma_valid_i,
   .dma_dac_i, .dma_addr_i, .dma_pa_valid_o, .dma_pa_o, .dma_err_o,
   .pio_valid_i, .pio_addr_i, .pio_fwd_o, .pio_addr_o, .int_a_i, .int_b_i,
   .int_c_i, .int_d_i, .irq_o, .card_present_i, .card_cap_i, .bus_speed_o
);

// File: tb/phba_card_model.sv
// card model: bus masters that request, hold a grant, then rest
`timescale 1ns/100ps
module phba_card_model #(
   parameter int N = 4,
   parameter int HOLD = 3
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // arbitration
   input wire logic [N-1:0] want_i,
   input wire logic [N-1:0] gnt_i,
   output logic [N-1:0] req_o
);
   logic [1:0] rest_ff [N];
   logic [3:0] cnt_ff [N];
   // a card gives up the bus after HOLD granted cycles, so rotation shows
   // cards stand for configured ones: enables set line size
   // latency cause register are not modelled
   always_comb
      for (int i = 0; i < N; i++)
         req_o[i] = want_i[i] && rest_ff[i] == 2'h0;
   always_ff @(posedge clock_i or negedge resetn_i)
      for (int i = 0; i < N; i++)
         if (!resetn_i)
         begin
            cnt_ff[i] <= 4'h0;
            rest_ff[i] <= 2'h0;
         end
         else if (rest_ff[i] != 2'h0)
            rest_ff[i] <= rest_ff[i] - 2'h1;
         else if (gnt_i[i] && req_o[i])
         begin
            cnt_ff[i] <= (cnt_ff[i] == 4'(HOLD - 1)) ? 4'h0 : cnt_ff[i] + 4'h1;
            if (cnt_ff[i] == 4'(HOLD - 1))
               rest_ff[i] <= 2'h2;
         end
endmodule

// File: tb/phba_top_test.sv
// testbench: register, arbiter, dma, pio, irq and speed scenarios
`timescale 1ns/100ps
module phba_top_test;
   import phba_pkg::*;
   logic clock_i, resetn_i, ce_i, reg_wr_i, reg_rd_i, pio_valid_i, pio_fwd_o;
   logic dma_valid_i, dma_dac_i, dma_lock_i, dma_sbo_i, dma_sdone_i;
   logic dma_pa_valid_o, dma_err_o;
   logic [7:0] reg_addr_i, wr_issue_i, wr_done_i, irq_o;
   logic [7:0] int_a_i, int_b_i, int_c_i, int_d_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, pio_addr_o, v, ints;
   logic [3:0] bus_req_i, bus_gnt_o, want, card_cap_i;
   logic [63:0] dma_addr_i, dma_data_i, dma_data_o, pio_addr_i;
   logic [49:0] dma_pa_o;
   logic [1:0] card_present_i, card_pcix_i, bus_speed_o;
   logic [2:0] idx [8];
   int fails, n_tests;
   assign {int_d_i, int_c_i, int_b_i, int_a_i} = ints;
   phba_top #(.NMAP(8), .NREQ(4)) i_phba_top (
      .clock_i, .resetn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .bus_req_i, .bus_gnt_o, .dma_valid_i,
      .dma_dac_i, .dma_addr_i, .dma_data_i, .dma_lock_i, .dma_sbo_i,
      .dma_sdone_i, .dma_pa_valid_o, .dma_pa_o, .dma_data_o, .dma_err_o,
      .wr_issue_i, .wr_done_i, .int_a_i, .int_b_i, .int_c_i, .int_d_i,
      .irq_o, .pio_valid_i, .pio_addr_i, .pio_fwd_o, .pio_addr_o,
      .card_present_i, .card_pcix_i, .card_cap_i, .bus_speed_o);
   phba_card_model #(.N(4), .HOLD(3)) i_phba_card_model (.clock_i,
      .resetn_i, .want_i(want), .gnt_i(bus_gnt_o), .req_o(bus_req_i));
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // ignored lock and snoop lines are raised with every wide transfer
   task automatic dma(input logic dac, input logic [63:0] a);
      @(posedge clock_i);
      dma_valid_i <= 1'b1;
      dma_dac_i <= dac;
      dma_addr_i <= a;
      dma_data_i <= ~a;
      {dma_lock_i, dma_sbo_i, dma_sdone_i} <= {3{dac}};
      @(posedge clock_i);
      dma_valid_i <= 1'b0;
      {dma_lock_i, dma_sbo_i, dma_sdone_i} <= 3'b000;
      @(posedge clock_i);
      #1;
   endtask
   task automatic pio(input logic [63:0] a, input logic f);
      @(posedge clock_i);
      pio_valid_i <= 1'b1;
      pio_addr_i <= a;
      @(posedge clock_i);
      pio_valid_i <= 1'b0;
      #1 chk(pio_fwd_o, f);
      if (f)
         chk(pio_addr_o, a[31:0]);
   endtask
   task automatic spd(input logic [1:0] p, input logic [1:0] x,
      input logic [3:0] c, input logic [1:0] e);
      @(posedge clock_i);
      card_present_i <= p;
      card_pcix_i <= x;
      card_cap_i <= c;
      @(posedge clock_i);
      #1 chk(bus_speed_o, e);
   endtask
   task automatic arb(input logic [3:0] w, input logic [15:0] exp);
      logic [3:0] prev;
      int n;
      prev = 4'h0;
      n = 0;
      @(posedge clock_i);
      want <= w;
      for (int t = 0; t < 200 && n < 4; t++)
      begin
         @(posedge clock_i);
         #1;
         if (bus_gnt_o !== prev && bus_gnt_o !== 4'h0)
         begin
            chk(bus_gnt_o, exp[n*4 +: 4]);
            n++;
         end
         prev = bus_gnt_o;
      end
      chk(n, 4);
      @(posedge clock_i);
      want <= 4'h0;
   endtask
   initial
   begin
      #100000;
      fails++;
      report_and_stop();
   end
   initial
   begin
      {fails, n_tests} = '0;
      {resetn_i, reg_wr_i, reg_rd_i, pio_valid_i, dma_valid_i} = '0;
      {dma_dac_i, dma_lock_i, dma_sbo_i, dma_sdone_i, ce_i} = 5'b00001;
      {reg_addr_i, reg_wdata_i, dma_addr_i, dma_data_i, pio_addr_i} = '0;
      {wr_issue_i, wr_done_i, ints, want} = '0;
      {card_present_i, card_pcix_i, card_cap_i} = '0;
      repeat (6) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(PHBA_REG_CTRL, v);
      chk(v, PHBA_CTRL_RST);
      rd(PHBA_REG_PIOLIM, v);
      chk(v, PHBA_PIOLIM_RST);
      rd(PHBA_REG_GROUP, v);
      chk(v, PHBA_GROUP_RST);
      rd(8'h3C, v);
      chk(v, PHBA_BAD_RD);
      spd(2'b01, 2'b01, 4'h3, PHBA_SPD_133);
      spd(2'b11, 2'b11, 4'hF, PHBA_SPD_100);
      spd(2'b11, 2'b00, 4'hF, PHBA_SPD_66);
      spd(2'b11, 2'b11, 4'h9, PHBA_SPD_66);
      spd(2'b11, 2'b01, 4'h7, PHBA_SPD_66);
      spd(2'b10, 2'b00, 4'hC, PHBA_SPD_66);
      spd(2'b11, 2'b00, 4'h4, PHBA_SPD_33);
      spd(2'b00, 2'b00, 4'h0, PHBA_SPD_33);
      wr(PHBA_REG_CTRL, 32'h0000_0003);
      spd(2'b01, 2'b01, 4'h3, PHBA_SPD_100);
      wr(PHBA_REG_CTRL, PHBA_CTRL_RST);
      pio(64'h0000_0000_0000_1000, 1'b1);
      pio(64'h0000_0000_03FF_FFFC, 1'b1);
      pio(64'h0000_0000_0400_0000, 1'b0);
      pio(64'h0000_0001_0000_1000, 1'b0);
      wr(PHBA_REG_PIOBASE, 32'h0000_0100);
      pio(64'h0000_0000_0000_0080, 1'b0);
      pio(64'h0000_0000_0000_0100, 1'b1);
      for (int l = 0; l < 4; l++)
         for (int s = 0; s < 8; s++)
         begin
            @(posedge clock_i);
            ints <= 32'h0000_0001 << (l * 8 + s);
            @(posedge clock_i);
            #1 chk(irq_o, 8'h01 << ((s + 4 * (l % 2)) % 8));
         end
      @(posedge clock_i);
      ints <= 32'h0000_1101;
      @(posedge clock_i);
      #1 chk(irq_o, 8'h11);
      // a write still in flight must hold back the slot's interrupt
      @(posedge clock_i);
      ints <= 32'h0000_0000;
      wr_issue_i <= 8'h04;
      @(posedge clock_i);
      wr_issue_i <= 8'h00;
      ints <= 32'h0000_0004;
      repeat (3) @(posedge clock_i);
      #1 chk(irq_o, 8'h00);
      @(posedge clock_i);
      wr_done_i <= 8'h04;
      @(posedge clock_i);
      wr_done_i <= 8'h00;
      repeat (3) @(posedge clock_i);
      #1 chk(irq_o, 8'h04);
      for (int i = 0; i < 8; i++)
      begin
         wr(PHBA_REG_MAPADDR, 32'h0000_1000 + i);
         wr(PHBA_REG_MAPREQ, 32'h0000_0000);
         rd(PHBA_REG_MAPRES, v);
         chk(v[31:30], 2'b10);
         idx[i] = v[2:0];
      end
      wr(PHBA_REG_MAPREQ, 32'h0000_0000);
      rd(PHBA_REG_MAPRES, v);
      chk(v[31:30], 2'b01);
      rd(PHBA_REG_STAT, v);
      chk(v[7:0], 8'hFF);
      dma(1'b0, {49'h0, idx[5], 12'hABC});
      chk(dma_pa_valid_o, 1'b1);
      chk(dma_pa_o, {38'h1005, 12'hABC});
      dma(1'b1, 64'hFFFF_C123_4567_89A8);
      chk(dma_pa_valid_o, 1'b1);
      chk(dma_pa_o, 50'h3_C123_4567_89A8);
      chk(dma_data_o, ~64'hFFFF_C123_4567_89A8);
      wr(PHBA_REG_MAPFREE, {29'h0, idx[5]});
      dma(1'b0, {49'h0, idx[5], 12'hABC});
      chk(dma_err_o, 1'b1);
      arb(4'hF, 16'h8421);
      wr(PHBA_REG_GROUP, 32'h0000_000C);
      arb(4'hF, 16'h8484);
      report_and_stop();
   end
endmodule
